// *** hdl/ieq_defs.vh ***
`ifndef IEQ_DEFS_VH
`define IEQ_DEFS_VH

// ----------------------------------------------------------------
// Code and field widths
// ----------------------------------------------------------------
`define IEQ_CODE_W 17
`define IEQ_CAUSE_W 5
`define IEQ_ESR_W 8
`define IEQ_DEPTH 16
`define IEQ_PTR_W 4
`define IEQ_CNT_W 5
`define IEQ_EXP_W 16
`define IEQ_EXP_MAX 16'h7d00

// ----------------------------------------------------------------
// Event status bit positions
// ----------------------------------------------------------------
`define IEQ_ESR_CME 5
`define IEQ_ESR_EXE 4
`define IEQ_ESR_DDE 3
`define IEQ_ESR_QYE 2

// ----------------------------------------------------------------
// Error codes, 17-bit two's complement
// ----------------------------------------------------------------
`define IEQ_NO_ERROR 17'h00000
`define IEQ_E_OVERFLOW 17'h1fea2
`define IEQ_E_CMD 17'h1ff9c
`define IEQ_E_GET 17'h1ff97
`define IEQ_E_SUFFIX 17'h1ff8e
`define IEQ_E_NUMERIC 17'h1ff88
`define IEQ_E_EXPONENT 17'h1ff85
`define IEQ_E_STRING 17'h1ff69
`define IEQ_E_EXEC 17'h1ff38
`define IEQ_E_PROTECTED 17'h1ff35
`define IEQ_E_PARAM 17'h1ff24
`define IEQ_E_CONFLICT 17'h1ff23
`define IEQ_E_RANGE 17'h1ff22
`define IEQ_E_MEMORY 17'h1ff1f
`define IEQ_E_QUESTION 17'h1ff19
`define IEQ_E_HW_FAULT 17'h1ff10
`define IEQ_E_HW_MISSING 17'h1ff0f
`define IEQ_E_PROG_NAME 17'h1fee6
`define IEQ_E_PROG_RUN 17'h1fee4
`define IEQ_E_PROG_SYNTAX 17'h1fee3
`define IEQ_E_MEM_USE 17'h1fede

// Class bounds
`define IEQ_CME_LO 17'h1ff39
`define IEQ_CME_HI 17'h1ff9c
`define IEQ_EXE_LO 17'h1fed5
`define IEQ_EXE_HI 17'h1ff38
`define IEQ_DDE_LO 17'h1fe71
`define IEQ_DDE_HI 17'h1fed4
`define IEQ_QYE_LO 17'h1fe0d
`define IEQ_QYE_HI 17'h1fe70

// ----------------------------------------------------------------
// Cause numbers on the raise port
// ----------------------------------------------------------------
`define IEQ_C_CMD 5'h00
`define IEQ_C_GET 5'h01
`define IEQ_C_SUFFIX 5'h02
`define IEQ_C_NUMERIC 5'h03
`define IEQ_C_STRING 5'h04
`define IEQ_C_EXEC 5'h05
`define IEQ_C_PROTECTED 5'h06
`define IEQ_C_PARAM 5'h07
`define IEQ_C_CONFLICT 5'h08
`define IEQ_C_RANGE 5'h09
`define IEQ_C_MEMORY 5'h0a
`define IEQ_C_QUESTION 5'h0b
`define IEQ_C_HW_FAULT 5'h0c
`define IEQ_C_HW_MISSING 5'h0d
`define IEQ_C_PROG_NAME 5'h0e
`define IEQ_C_PROG_RUN 5'h0f
`define IEQ_C_PROG_SYNTAX 5'h10
`define IEQ_C_MEM_USE 5'h11
`define IEQ_C_RAW 5'h1f

// ----------------------------------------------------------------
// Register map (APB byte addresses)
// ----------------------------------------------------------------
`define IEQ_A_RAISE 12'h000
`define IEQ_A_QUERY 12'h004
`define IEQ_A_COUNT 12'h008
`define IEQ_A_ESR 12'h00c
`define IEQ_A_CTRL 12'h010
`define IEQ_CTRL_CLS 0
`define IEQ_CTRL_ESRCLR 1
`define IEQ_RAISE_RAW 31
`define IEQ_RAISE_EXP 30
`define IEQ_EXP_LSB 5

`endif

// *** hdl/ieq_error_queue.v ***
// Operation
// R01: Errors leave the queue oldest first, in arrival order.
// R02: Pushing into a full queue overwrites the newest entry with -350.
// R03: Query on empty queue returns 0 and changes nothing.
// R04: Clear-status empties the queue; reading the last entry empties it.
// R05: Standard errors negative; instrument-specific errors positive.
// R06: Queued codes -199..-100 set event status bit 5.
// R07: Queued codes -299..-200 set event status bit 4.
// R08: Execution checks act on rounded, evaluated values only.
// R09: Exponent above 32000 gives -123; numeric fault -120; generic -100.
// R10: Group execute trigger inside a message gives -105.
// R11: Header suffix out of range gives -114.
// R12: Bad quoted string length or character gives -151.
// R13: Refused password-protected command gives -203.
// R14: Parameter fault gives -220; lack of memory gives -225.
// R15: Setting refused by current state gives -221.
// R16: Interpreted value out of range gives -222.
// R17: Doubtful measurement accuracy gives -231.
// R18: Hardware fault blocking a command gives -240.
// R19: Missing hardware gives -241.
// R20: Invalid or unselected sequence program gives -282.
// R21: Illegal operation on a running sequence program gives -284.
// R22: Program definition error -285; memory or handle misuse -290.
// R23: Device-specific class codes set event status bit 3.
// R24: Queued codes -499..-400 set event status bit 2.
// R25: Depth is a parameter; entries hold -899 through +32767.
`timescale 1ns/1ps
`include "ieq_defs.vh"

module ieq_error_queue #(
    parameter DEPTH = `IEQ_DEPTH,
    parameter PTR_W = `IEQ_PTR_W,
    parameter CNT_W = `IEQ_CNT_W
) (
    input wire clock,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg [`IEQ_ESR_W-1:0] event_status,
    output reg queue_nonempty
);

// ----------------------------------------------------------------
// Storage
// ----------------------------------------------------------------
reg [`IEQ_CODE_W-1:0] entry [0:DEPTH-1]; // R25
reg [PTR_W-1:0] head;
reg [PTR_W-1:0] tail;
reg [CNT_W-1:0] count;

wire access = psel && penable && !pready;
wire wr = access && pwrite;
wire rd = access && !pwrite;
wire raise_wr = wr && (paddr == `IEQ_A_RAISE);
wire query_rd = rd && (paddr == `IEQ_A_QUERY);
wire ctrl_wr = wr && (paddr == `IEQ_A_CTRL);
wire cls = ctrl_wr && pwdata[`IEQ_CTRL_CLS];
wire esr_clr = ctrl_wr && pwdata[`IEQ_CTRL_ESRCLR];
wire mapped = (paddr == `IEQ_A_RAISE) || (paddr == `IEQ_A_QUERY) ||
    (paddr == `IEQ_A_COUNT) || (paddr == `IEQ_A_ESR) ||
    (paddr == `IEQ_A_CTRL);

// ----------------------------------------------------------------
// Cause to code
// ----------------------------------------------------------------
wire [`IEQ_CAUSE_W-1:0] cause = pwdata[`IEQ_CAUSE_W-1:0];
wire [`IEQ_EXP_W-1:0] exp_mag =
    pwdata[`IEQ_EXP_LSB+`IEQ_EXP_W-1:`IEQ_EXP_LSB];
reg [`IEQ_CODE_W-1:0] new_code;

// Execution causes are raised by the parser only once rounding and
// evaluation are done, so range checks arrive already resolved.
always @* begin // R08
    new_code = `IEQ_E_CMD; // R09
    if (pwdata[`IEQ_RAISE_RAW]) begin
        new_code = pwdata[`IEQ_CODE_W-1:0]; // R05
    end else if (pwdata[`IEQ_RAISE_EXP]) begin
        if (exp_mag > `IEQ_EXP_MAX)
            new_code = `IEQ_E_EXPONENT; // R09
        else
            new_code = `IEQ_E_NUMERIC; // R09
    end else begin
        case (cause)
            `IEQ_C_CMD: new_code = `IEQ_E_CMD; // R09
            `IEQ_C_GET: new_code = `IEQ_E_GET; // R10
            `IEQ_C_SUFFIX: new_code = `IEQ_E_SUFFIX; // R11
            `IEQ_C_NUMERIC: new_code = `IEQ_E_NUMERIC; // R09
            `IEQ_C_STRING: new_code = `IEQ_E_STRING; // R12
            `IEQ_C_EXEC: new_code = `IEQ_E_EXEC;
            `IEQ_C_PROTECTED: new_code = `IEQ_E_PROTECTED; // R13
            `IEQ_C_PARAM: new_code = `IEQ_E_PARAM; // R14
            `IEQ_C_CONFLICT: new_code = `IEQ_E_CONFLICT; // R15
            `IEQ_C_RANGE: new_code = `IEQ_E_RANGE; // R16
            `IEQ_C_MEMORY: new_code = `IEQ_E_MEMORY; // R14
            `IEQ_C_QUESTION: new_code = `IEQ_E_QUESTION; // R17
            `IEQ_C_HW_FAULT: new_code = `IEQ_E_HW_FAULT; // R18
            `IEQ_C_HW_MISSING: new_code = `IEQ_E_HW_MISSING; // R19
            `IEQ_C_PROG_NAME: new_code = `IEQ_E_PROG_NAME; // R20
            `IEQ_C_PROG_RUN: new_code = `IEQ_E_PROG_RUN; // R21
            `IEQ_C_PROG_SYNTAX: new_code = `IEQ_E_PROG_SYNTAX; // R22
            `IEQ_C_MEM_USE: new_code = `IEQ_E_MEM_USE; // R22
            default: new_code = `IEQ_E_CMD;
        endcase
    end
end

// ----------------------------------------------------------------
// Queue control
// ----------------------------------------------------------------
wire full = (count == DEPTH[CNT_W-1:0]);
wire empty = (count == {CNT_W{1'b0}});
wire pop = query_rd && !empty; // R03
wire push = raise_wr && !cls;
wire [PTR_W-1:0] last = tail - {{(PTR_W-1){1'b0}}, 1'b1};
wire [`IEQ_CODE_W-1:0] stored = full ? `IEQ_E_OVERFLOW : new_code;

// Overflow replaces the newest slot, so the oldest errors survive.
always @(posedge clock or posedge reset) begin
    if (reset) begin
        head <= {PTR_W{1'b0}};
        tail <= {PTR_W{1'b0}};
        count <= {CNT_W{1'b0}};
    end else if (cls) begin
        head <= {PTR_W{1'b0}}; // R04
        tail <= {PTR_W{1'b0}};
        count <= {CNT_W{1'b0}};
    end else begin
        if (pop)
            head <= head + {{(PTR_W-1){1'b0}}, 1'b1}; // R01
        if (push && !full)
            tail <= tail + {{(PTR_W-1){1'b0}}, 1'b1}; // R01
        if (pop && !(push && !full))
            count <= count - {{(CNT_W-1){1'b0}}, 1'b1}; // R04
        else if (push && !full && !pop)
            count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
    end
end

genvar gi;
generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_entry
        always @(posedge clock or posedge reset) begin
            if (reset)
                entry[gi] <= `IEQ_NO_ERROR;
            else if (push && full && last == gi)
                entry[gi] <= `IEQ_E_OVERFLOW; // R02
            else if (push && !full && tail == gi)
                entry[gi] <= new_code; // R01
        end
    end
endgenerate

// ----------------------------------------------------------------
// Event status
// ----------------------------------------------------------------
// The stored code decides the class, so an overflow sets bit 3.
wire cme = ($signed(stored) >= $signed(`IEQ_CME_LO)) &&
    ($signed(stored) <= $signed(`IEQ_CME_HI));
wire exe = ($signed(stored) >= $signed(`IEQ_EXE_LO)) &&
    ($signed(stored) <= $signed(`IEQ_EXE_HI));
wire dde = (($signed(stored) >= $signed(`IEQ_DDE_LO)) &&
    ($signed(stored) <= $signed(`IEQ_DDE_HI))) ||
    ($signed(stored) > $signed(`IEQ_NO_ERROR));
wire qye = ($signed(stored) >= $signed(`IEQ_QYE_LO)) &&
    ($signed(stored) <= $signed(`IEQ_QYE_HI));
reg [`IEQ_ESR_W-1:0] set_bits;

always @* begin
    set_bits = {`IEQ_ESR_W{1'b0}};
    set_bits[`IEQ_ESR_CME] = push && cme; // R06
    set_bits[`IEQ_ESR_EXE] = push && exe; // R07
    set_bits[`IEQ_ESR_DDE] = push && dde; // R23
    set_bits[`IEQ_ESR_QYE] = push && qye; // R24
end

// Set wins over a clear in the same cycle.
always @(posedge clock or posedge reset) begin
    if (reset)
        event_status <= {`IEQ_ESR_W{1'b0}};
    else if (esr_clr)
        event_status <= set_bits;
    else
        event_status <= event_status | set_bits;
end

// ----------------------------------------------------------------
// APB slave, one wait state
// ----------------------------------------------------------------
wire [`IEQ_CODE_W-1:0] head_code = empty ? `IEQ_NO_ERROR : entry[head];
reg [31:0] next_prdata;

always @* begin
    next_prdata = 32'h00000000;
    case (paddr)
        `IEQ_A_QUERY: next_prdata = {{(32-`IEQ_CODE_W){head_code[
            `IEQ_CODE_W-1]}}, head_code}; // R03
        `IEQ_A_COUNT: next_prdata = {{(32-CNT_W){1'b0}}, count};
        `IEQ_A_ESR: next_prdata = {{(32-`IEQ_ESR_W){1'b0}}, event_status};
        default: next_prdata = 32'h00000000;
    endcase
end

always @(posedge clock or posedge reset) begin
    if (reset) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
        queue_nonempty <= 1'b0;
    end else begin
        pready <= access;
        pslverr <= access && !mapped;
        prdata <= rd ? next_prdata : 32'h00000000;
        queue_nonempty <= !cls && ((push) || (count >
            {{(CNT_W-1){1'b0}}, pop}));
    end
end

endmodule // ieq_error_queue

// *** verif/ieq_checker_assertions.sv ***
`timescale 1ns/1ps
`include "ieq_defs.vh"
module ieq_checker #(
    parameter DEPTH = 4,
    parameter PTR_W = 2,
    parameter CNT_W = 3
) (
    input wire clock,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [`IEQ_ESR_W-1:0] event_status,
    input wire queue_nonempty
);
    wire take = psel && penable && !pready;
    wire hit = paddr <= `IEQ_A_CTRL && paddr[1:0] == 2'h0;
    wire clr = take && pwrite && paddr == `IEQ_A_CTRL && pwdata[1];
    wire pop = take && !pwrite && paddr == `IEQ_A_QUERY;
    wire [3:0] spare = {event_status[7:6], event_status[1:0]};
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    sequence s_take; take; endsequence
    sequence s_ans; pready ##1 !pready; endsequence
    ready_pulse_a: assert property (s_take |=> s_ans)
        else $error("pready is not a one cycle answer");
    ready_cause_a: assert property (pready |-> $past(psel && penable))
        else $error("pready without a request");
    data_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    bad_addr_a: assert property (take && !hit |=> pslverr && !prdata)
        else $error("unmapped access not refused");
    good_addr_a: assert property (take && hit |=> !pslverr)
        else $error("mapped access refused");
    empty_query_a: assert property (pop && !queue_nonempty |=> !prdata)
        else $error("query on empty queue not zero");
    esr_spare_a: assert property (spare == 4'h0)
        else $error("unused event status bit set");
    // Bits only drop through the control write; reads must leave them
    esr_hold_a: assert property (
        (|($past(event_status) & ~event_status)) |-> $past(clr))
        else $error("event status bit lost");
endmodule // ieq_checker
bind ieq_error_queue ieq_checker #(.DEPTH(DEPTH), .PTR_W(PTR_W),
    .CNT_W(CNT_W)) chk_u (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_status(event_status), .queue_nonempty(queue_nonempty));

// *** verif/ieq_host_model.sv ***
`timescale 1ns/1ps
module ieq_host_model (
    input wire clock,
    output reg psel,
    output reg penable,
    output reg pwrite,
    output reg [11:0] paddr,
    output reg [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = 47'h0;
    end
    // Request held until pready is seen high at a rising edge
    task xfer(input w, input [11:0] a, input [31:0] d,
        output [31:0] r, output e);
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'h0;
        // Stale data inverted so it never passes for a live value
        pwdata <= ~d;
    endtask
endmodule // ieq_host_model

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`include "ieq_defs.vh"
module testbench;
    logic clock = 1'b0;
    logic reset = 1'b1;
    wire psel, penable, pwrite, pready, pslverr, queue_nonempty;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [7:0] event_status;
    logic [31:0] rv;
    logic re;
    int fails = 0, num_checks = 0, cycles = 0;
    int code_tab [18] = '{-100, -105, -114, -120, -151, -200, -203, -220,
        -221, -222, -225, -231, -240, -241, -282, -284, -285, -290};
    ieq_error_queue #(.DEPTH(4), .PTR_W(2), .CNT_W(3)) dut_u (
        .clock(clock), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .event_status(event_status),
        .queue_nonempty(queue_nonempty));
    ieq_host_model host_u (.clock(clock), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    initial begin
        forever #10 clock = ~clock;
    end
    task wr(input [11:0] a, input [31:0] d);
        host_u.xfer(1'b1, a, d, rv, re);
    endtask
    task chk(input [31:0] got, input [31:0] exp, input string n);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
        end
    endtask
    task rd(input [11:0] a, input [31:0] exp, input string n);
        host_u.xfer(1'b0, a, 32'h0, rv, re);
        chk(rv, exp, n);
    endtask
    task final_report;
        if (fails == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task t_clear;
        rd(`IEQ_A_QUERY, 32'h0, "empty query");
        rd(`IEQ_A_COUNT, 32'h0, "count after empty query");
        rd(12'h020, 32'h0, "unmapped data");
        chk(re, 1'b1, "unmapped error");
        wr(`IEQ_A_RAISE, 32'h5);
        wr(`IEQ_A_RAISE, 32'h6);
        wr(`IEQ_A_CTRL, 32'h1);
        rd(`IEQ_A_COUNT, 32'h0, "count after clear");
        rd(`IEQ_A_QUERY, 32'h0, "query after clear");
        chk(queue_nonempty, 1'b0, "nonempty after clear");
    endtask
    task t_order;
        for (int g = 0; g < 18; g += 3) begin
            for (int k = 0; k < 3; k++) wr(`IEQ_A_RAISE, g + k);
            rd(`IEQ_A_QUERY, code_tab[g], "cause");
            rd(`IEQ_A_QUERY, code_tab[g + 1], "cause");
            rd(`IEQ_A_QUERY, code_tab[g + 2], "cause");
        end
    endtask
    // Raw code, or exponent magnitude when x is set
    task one(input int v, input bit x, input [7:0] e);
        wr(`IEQ_A_CTRL, 32'h2);
        wr(`IEQ_A_RAISE, x ? 32'h40000000 | (v << 5)
            : 32'h80000000 | (v & 32'h1ffff));
        rd(`IEQ_A_ESR, e, "class bit");
        chk(event_status, e, "class port");
        rd(`IEQ_A_QUERY, x ? (v > 32000 ? -123 : -120) : v, "code");
    endtask
    task t_class;
        one(-199, 1'b0, 8'h20);
        one(-100, 1'b0, 8'h20);
        one(-200, 1'b0, 8'h10);
        one(-299, 1'b0, 8'h10);
        one(-300, 1'b0, 8'h08);
        one(-400, 1'b0, 8'h04);
        one(1301, 1'b0, 8'h08);
        one(32000, 1'b1, 8'h20);
        one(32001, 1'b1, 8'h20);
        // Cause numbers past the table fall back to the generic code
        wr(`IEQ_A_RAISE, 32'h12);
        rd(`IEQ_A_QUERY, -100, "other cause");
    endtask
    task t_overflow;
        wr(`IEQ_A_CTRL, 32'h2);
        for (int i = 0; i < 5; i++) wr(`IEQ_A_RAISE, i);
        rd(`IEQ_A_COUNT, 32'h4, "full count");
        rd(`IEQ_A_ESR, 32'h28, "overflow class");
        for (int i = 0; i < 4; i++)
            rd(`IEQ_A_QUERY, i < 3 ? code_tab[i] : -350, "drain");
        rd(`IEQ_A_QUERY, 32'h0, "after drain");
        chk(queue_nonempty, 1'b0, "drained");
    endtask
    initial begin
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        t_clear;
        t_order;
        t_class;
        t_overflow;
        final_report;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            final_report;
        end
    end
endmodule // testbench
